//--- ipb_pkg.sv
package ipb_pkg;

  // ****************************************************************
  // parameter numbers; byte address is four times the number
  // ****************************************************************
  localparam logic [6:0] VIS_CAL_BIAS               = 7'h23;
  localparam logic [6:0] VIS_TWEAK_BIAS             = 7'h24;
  localparam logic [6:0] NIR_ELEC_CAL_ENABLE        = 7'h25;
  localparam logic [6:0] NIR_CAL_BIAS               = 7'h26;
  localparam logic [6:0] NIR_TWEAK_BIAS             = 7'h27;
  localparam logic [6:0] SMW_ELEC_CAL_ENABLE        = 7'h28;
  localparam logic [6:0] SMW_CAL_BIAS               = 7'h29;
  localparam logic [6:0] SMW_TWEAK_BIAS             = 7'h2a;
  localparam logic [6:0] SMW_DETECTOR_BIAS          = 7'h2b;
  localparam logic [6:0] LW_ELEC_CAL_ENABLE         = 7'h2c;
  localparam logic [6:0] LW_CAL_BIAS                = 7'h2d;
  localparam logic [6:0] LW_TWEAK_BIAS              = 7'h2e;
  localparam logic [6:0] LW_DETECTOR_BIAS           = 7'h2f;
  localparam logic [6:0] SMW_CHARGE_SUBTRACT_ENABLE = 7'h30;
  localparam logic [6:0] LW_CHARGE_SUBTRACT_ENABLE  = 7'h31;
  localparam logic [6:0] FP_PROCESSOR_MEMORY_SELECT = 7'h32;
  localparam logic [6:0] PACKET_TYPE_SELECT         = 7'h33;
  localparam logic [6:0] PV_DC_RESTORE_ENABLE       = 7'h34;
  localparam logic [6:0] PC_DC_RESTORE_ENABLE       = 7'h35;
  localparam logic [6:0] SPARE_54                   = 7'h36;
  localparam logic [6:0] SPARE_58                   = 7'h3a;
  localparam logic [6:0] ENCODER_VIEW_OFFSET        = 7'h3b;
  localparam logic [6:0] RADIANCE_TABLE_SELECT      = 7'h3c;
  localparam logic [6:0] OFFSET_TABLE_SELECT        = 7'h3d;
  localparam logic [6:0] GAIN_TABLE_SELECT          = 7'h3e;
  localparam logic [6:0] TEST_RADIANCE_VALUE        = 7'h3f;
  localparam logic [6:0] TEST_PV_OFFSET_VALUE       = 7'h40;
  localparam logic [6:0] TEST_PC_OFFSET_VALUE       = 7'h41;
  localparam logic [6:0] TEST_GAIN_VALUE            = 7'h42;
  localparam logic [6:0] VIS_CAL_STEP_COUNT         = 7'h43;
  localparam logic [6:0] NIR_CAL_STEP_COUNT         = 7'h44;
  localparam logic [6:0] SMW_CAL_STEP_COUNT         = 7'h45;
  localparam logic [6:0] LW_CAL_STEP_COUNT          = 7'h46;
  localparam logic [6:0] PHOTODIODE_HEATER_ENABLE   = 7'h47;
  localparam logic [6:0] SPHERE_FEEDBACK_MODE       = 7'h48;
  localparam logic [6:0] LAMP_OVERVOLTAGE_SHUTDOWN  = 7'h49;
  localparam logic [6:0] LAMP_LEVEL_SELECT          = 7'h4a;
  localparam logic [6:0] LAMP_POWER_SELECT          = 7'h4b;
  localparam logic [6:0] IR_SOURCE_ENABLE           = 7'h4c;
  localparam logic [6:0] LOAD_DUMP_CLASS_A          = 7'h4d;
  localparam logic [6:0] LOAD_DUMP_CLASS_B          = 7'h4e;
  // lamp configuration slots (3x10W, 2x10W, 1x10W, 1x1W) and status
  localparam logic [6:0] LAMP_CFG_FIRST             = 7'h50;
  localparam logic [6:0] LAMP_CFG_LAST              = 7'h53;
  localparam logic [6:0] BANK_STATUS                = 7'h54;

  // ****************************************************************
  // value ranges, encodings, reset values
  // ****************************************************************
  localparam logic [15:0] CODE8_MAX     = 16'h00ff;
  localparam logic [15:0] SWITCH_MAX    = 16'h0001;
  localparam logic [15:0] STEP_MIN      = 16'h0001;
  localparam logic [15:0] STEP_MAX      = 16'h0028;
  localparam logic [15:0] PC_OFFSET_MAX = 16'h3fff;
  localparam logic [15:0] ENC_POS_MAX   = 16'h1fff;
  localparam logic [15:0] ENC_NEG_MIN   = 16'he000;
  localparam logic [15:0] LOG_STATE_MAX = 16'h000f;
  localparam logic [15:0] LAMP_1W       = 16'h0001;
  localparam logic [15:0] LAMP_10W      = 16'h0002;
  localparam logic [15:0] LAMP_20W      = 16'h0003;
  localparam logic [15:0] LAMP_30W      = 16'h0004;
  localparam logic [15:0] OVP_DISABLE   = 16'h0001;
  localparam logic [3:0]  CFG_RESET [0:3] = '{4'he, 4'h6, 4'h8, 4'h2};
  localparam logic [3:0]  CFG_MASK  [0:3] = '{4'hf, 4'hf, 4'hf, 4'h3};
  localparam logic [4:0]  CFG_ONES  [0:3] = '{5'h03, 5'h02, 5'h01, 5'h01};
  // status word fields
  localparam int ST_LAMP_LSB  = 0;
  localparam int ST_BUSY      = 7;
  localparam int ST_EVENT_LSB = 8;

  // ****************************************************************
  // log event codes and timing
  // ****************************************************************
  localparam logic [7:0] CFG_EVENT [0:3] = '{8'h16, 8'h15, 8'h14, 8'h17};
  localparam logic [7:0] EV_BAD_LAMP_CMD = 8'h18;
  localparam logic [7:0] EV_BAD_PARAM    = 8'h48;
  localparam logic [7:0] EV_BAD_VALUE    = 8'h49;
  localparam int unsigned LAMP_OFF_S      = 3;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned LAMP_OFF_CYCLES = LAMP_OFF_S * CLK_HZ;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef logic [15:0] ipb_word_t;
  typedef ipb_word_t [0:43] ipb_bank_t;   // element 0 is parameter 35
  localparam ipb_bank_t PARAM_RESET = '{
    16'h001d, 16'h004f, 16'h0000, 16'h001d, 16'h004f, 16'h0000, 16'h001d,
    16'h004f, 16'h00be, 16'h0000, 16'h001d, 16'h004f, 16'h00b9, 16'h0000,
    16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0001,
    16'h03e8, 16'h0080, 16'h2080, 16'h0000, 16'h000a, 16'h000a, 16'h0028,
    16'h000a, 16'h0000, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0000,
    16'h0000, 16'h0000};
  typedef struct packed {
    logic       radianceFb;   // sphere feedback: 1 radiance, 0 current
    logic       ovpDisable;   // overvoltage shutdown disabled
    logic       lampHigh;     // lamp level high
    logic [5:0] lampOn;       // [5:4] lamps 5,6; [3:0] lamps 1..4
    logic       irSourceOn;
    logic       heaterOn;
  } ipb_cal_t;
  typedef struct packed {
    logic       valid;        // one-cycle pulse
    logic [7:0] code;
  } ipb_event_t;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_DARK = 3'b010,
    SEQ_SEND = 3'b100
  } ipb_seq_t;

endpackage : ipb_pkg

//--- ipb_instrument_parameter_bank.sv
`timescale 1ns/100ps
module ipb_instrument_parameter_bank #(
  parameter int unsigned LAMP_OFF_CYCLES = ipb_pkg::LAMP_OFF_CYCLES
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic [8:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  output ipb_pkg::ipb_bank_t paramBank,
  output ipb_pkg::ipb_cal_t  calCmd,
  output logic [7:0]         smwChargeSubBias,
  output logic [7:0]         lwChargeSubBias,
  output logic [13:0]        encoderOffset,
  output ipb_pkg::ipb_event_t logEvent
);

  // ****************************************************************
  // decode
  // ****************************************************************
  logic [6:0]         idx;         // parameter number
  logic [5:0]         pos;         // element in bank
  logic [1:0]         cfgSel;      // lamp configuration slot
  logic               aligned;     // word-aligned access
  logic               inBank;      // parameters 35..78
  logic               isSpare;     // spare numbers 54..58
  logic               isCfg;       // lamp configuration slots
  logic               lampIdx;     // write goes through dark sequence
  logic [3:0]         lampCfg [0:3];
  logic [7:0]         lastEvent;   // most recent event code
  ipb_pkg::ipb_seq_t  seqState;
  logic [31:0]        darkCnt;     // cycles spent with lamps off
  logic [6:0]         pendIdx;     // which parameter started the dark
  logic [5:0]         savedLamps;  // lamps before the dark interval
  logic               busy;
  logic               take;        // request completes at this edge
  logic               wrTake;
  logic               stall;
  logic [15:0]        curVal;
  logic [15:0]        merged;      // byte-lane merge of write data
  logic [15:0]        statusWord;
  logic [15:0]        readVal;
  logic               wrOk;
  logic               evHit;
  logic [7:0]         evCode;

  assign idx     = avs_address[8:2];
  assign aligned = (avs_address[1:0] == 2'b00);
  assign pos     = 6'(idx - ipb_pkg::VIS_CAL_BIAS);
  assign cfgSel  = 2'(idx - ipb_pkg::LAMP_CFG_FIRST);
  assign inBank  = (idx >= ipb_pkg::VIS_CAL_BIAS) &&
                   (idx <= ipb_pkg::LOAD_DUMP_CLASS_B);
  assign isSpare = (idx >= ipb_pkg::SPARE_54) && (idx <= ipb_pkg::SPARE_58);
  assign isCfg   = (idx >= ipb_pkg::LAMP_CFG_FIRST) &&
                   (idx <= ipb_pkg::LAMP_CFG_LAST);
  assign lampIdx = aligned && ((idx == ipb_pkg::SPHERE_FEEDBACK_MODE) ||
                   (idx == ipb_pkg::LAMP_OVERVOLTAGE_SHUTDOWN) ||
                   (idx == ipb_pkg::LAMP_POWER_SELECT));
  assign busy    = (seqState != ipb_pkg::SEQ_IDLE);
  assign take    = (avs_read || avs_write) && !avs_waitrequest;
  assign wrTake  = take && avs_write;
  // a lamp write during the dark interval is held off by waitrequest
  assign stall   = avs_write && lampIdx && busy;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // stored word of a parameter number
  function automatic ipb_pkg::ipb_word_t bankAt(input logic [6:0] i);
    return paramBank[6'(i - ipb_pkg::VIS_CAL_BIAS)];
  endfunction : bankAt

  // legal range of each stored parameter
  function automatic logic legalValue(input logic [6:0] i,
                                      input logic [15:0] v);
    logic ok;
    ok = 1'b0;
    case (i)
      ipb_pkg::VIS_CAL_BIAS, ipb_pkg::NIR_CAL_BIAS,
      ipb_pkg::SMW_CAL_BIAS, ipb_pkg::LW_CAL_BIAS:
        ok = (v <= ipb_pkg::CODE8_MAX);
      ipb_pkg::VIS_TWEAK_BIAS, ipb_pkg::NIR_TWEAK_BIAS,
      ipb_pkg::SMW_TWEAK_BIAS, ipb_pkg::LW_TWEAK_BIAS:
        ok = (v <= ipb_pkg::CODE8_MAX);
      ipb_pkg::SMW_DETECTOR_BIAS, ipb_pkg::LW_DETECTOR_BIAS:
        ok = (v <= ipb_pkg::CODE8_MAX);
      ipb_pkg::NIR_ELEC_CAL_ENABLE, ipb_pkg::SMW_ELEC_CAL_ENABLE,
      ipb_pkg::LW_ELEC_CAL_ENABLE:
        ok = (v <= ipb_pkg::SWITCH_MAX);
      ipb_pkg::SMW_CHARGE_SUBTRACT_ENABLE, ipb_pkg::LW_CHARGE_SUBTRACT_ENABLE:
        ok = (v <= ipb_pkg::SWITCH_MAX);
      ipb_pkg::FP_PROCESSOR_MEMORY_SELECT:
        ok = (v <= ipb_pkg::SWITCH_MAX);
      ipb_pkg::PACKET_TYPE_SELECT:
        ok = (v <= ipb_pkg::SWITCH_MAX);
      ipb_pkg::PV_DC_RESTORE_ENABLE, ipb_pkg::PC_DC_RESTORE_ENABLE:
        ok = (v <= ipb_pkg::SWITCH_MAX);
      ipb_pkg::ENCODER_VIEW_OFFSET:
        ok = (v <= ipb_pkg::ENC_POS_MAX) || (v >= ipb_pkg::ENC_NEG_MIN);
      ipb_pkg::RADIANCE_TABLE_SELECT, ipb_pkg::OFFSET_TABLE_SELECT,
      ipb_pkg::GAIN_TABLE_SELECT:
        ok = (v <= ipb_pkg::SWITCH_MAX);
      ipb_pkg::TEST_RADIANCE_VALUE, ipb_pkg::TEST_PV_OFFSET_VALUE,
      ipb_pkg::TEST_GAIN_VALUE:
        ok = (v <= ipb_pkg::CODE8_MAX);
      ipb_pkg::TEST_PC_OFFSET_VALUE:
        ok = (v <= ipb_pkg::PC_OFFSET_MAX);
      ipb_pkg::VIS_CAL_STEP_COUNT, ipb_pkg::NIR_CAL_STEP_COUNT,
      ipb_pkg::SMW_CAL_STEP_COUNT, ipb_pkg::LW_CAL_STEP_COUNT:
        ok = (v >= ipb_pkg::STEP_MIN) && (v <= ipb_pkg::STEP_MAX);
      ipb_pkg::PHOTODIODE_HEATER_ENABLE, ipb_pkg::IR_SOURCE_ENABLE:
        ok = (v <= ipb_pkg::SWITCH_MAX);
      ipb_pkg::SPHERE_FEEDBACK_MODE:
        ok = (v <= ipb_pkg::SWITCH_MAX);
      ipb_pkg::LAMP_OVERVOLTAGE_SHUTDOWN:
        ok = (v <= ipb_pkg::SWITCH_MAX);
      ipb_pkg::LAMP_LEVEL_SELECT:
        ok = (v <= ipb_pkg::SWITCH_MAX);
      ipb_pkg::LAMP_POWER_SELECT:
        ok = (v <= ipb_pkg::LAMP_30W);
      ipb_pkg::LOAD_DUMP_CLASS_A, ipb_pkg::LOAD_DUMP_CLASS_B:
        ok = (v <= ipb_pkg::LOG_STATE_MAX);
      default:
        ok = 1'b0;
    endcase
    return ok;
  endfunction : legalValue

  // lamp pattern for a lamp selector value
  function automatic logic [5:0] lampPattern(input logic [15:0] sel);
    logic [5:0] p;
    p = 6'h00;
    case (sel)
      ipb_pkg::LAMP_1W:  p = {lampCfg[3][1:0], 4'h0};
      ipb_pkg::LAMP_10W: p = {2'b00, lampCfg[2]};
      ipb_pkg::LAMP_20W: p = {2'b00, lampCfg[1]};
      ipb_pkg::LAMP_30W: p = {2'b00, lampCfg[0]};
      default:           p = 6'h00;
    endcase
    return p;
  endfunction : lampPattern

  // ****************************************************************
  // write checking
  // ****************************************************************
  // old value, then byte lanes 0 and 1 merged over it
  always_comb
  begin
    curVal = 16'h0000;
    if (inBank)
    begin
      curVal = paramBank[pos];
    end
    else if (isCfg)
    begin
      curVal = {12'h000, lampCfg[cfgSel]};
    end
    merged[15:8] = avs_byteenable[1] ? avs_writedata[15:8] : curVal[15:8];
    merged[7:0]  = avs_byteenable[0] ? avs_writedata[7:0] : curVal[7:0];
  end

  // accept or reject, and the event that goes with a reject
  always_comb
  begin
    wrOk   = 1'b0;
    evHit  = 1'b0;
    evCode = 8'h00;
    if (!aligned)
    begin
      evHit  = 1'b1;
      evCode = ipb_pkg::EV_BAD_PARAM;
    end
    else if (isSpare || (idx == ipb_pkg::BANK_STATUS))
    begin
      // spares and status ignore writes quietly
      wrOk = 1'b0;
    end
    else if (inBank)
    begin
      if (legalValue(idx, merged))
      begin
        wrOk = 1'b1;
      end
      else if (idx == ipb_pkg::LAMP_POWER_SELECT)
      begin
        evHit  = 1'b1;
        evCode = ipb_pkg::EV_BAD_LAMP_CMD;
      end
      else
      begin
        evHit  = 1'b1;
        evCode = ipb_pkg::EV_BAD_VALUE;
      end
    end
    else if (isCfg)
    begin
      // a configuration must light exactly the lamps its slot names
      if (((merged[3:0] & ~ipb_pkg::CFG_MASK[cfgSel]) == 4'h0) &&
          (merged[15:4] == 12'h000) &&
          (5'($countones(merged)) == ipb_pkg::CFG_ONES[cfgSel]))
      begin
        wrOk = 1'b1;
      end
      else
      begin
        evHit  = 1'b1;
        evCode = ipb_pkg::CFG_EVENT[cfgSel];
      end
    end
    else
    begin
      evHit  = 1'b1;
      evCode = ipb_pkg::EV_BAD_PARAM;
    end
  end

  // ****************************************************************
  // bus slave
  // ****************************************************************
  // waitrequest drops for one cycle, one edge after the request;
  // lamp writes wait while the dark interval runs
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
    end
    else if ((avs_read || avs_write) && avs_waitrequest && !stall)
    begin
      avs_waitrequest <= 1'b0;
    end
    else
    begin
      avs_waitrequest <= 1'b1;
    end
  end

  // status word: last event, sequencer busy, lamps driven
  always_comb
  begin
    statusWord = 16'h0000;
    statusWord[ipb_pkg::ST_LAMP_LSB +: 6]  = calCmd.lampOn;
    statusWord[ipb_pkg::ST_BUSY]           = busy;
    statusWord[ipb_pkg::ST_EVENT_LSB +: 8] = lastEvent;
  end

  // read mux; unknown numbers and spares read zero
  always_comb
  begin
    readVal = 16'h0000;
    if (aligned && inBank)
    begin
      readVal = paramBank[pos];
    end
    else if (aligned && isCfg)
    begin
      readVal = {12'h000, lampCfg[cfgSel]};
    end
    else if (aligned && (idx == ipb_pkg::BANK_STATUS))
    begin
      readVal = statusWord;
    end
  end

  // read data loaded with the waitrequest drop, held while low
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (avs_read && avs_waitrequest)
    begin
      avs_readdata <= {16'h0000, readVal};
    end
  end

  // ****************************************************************
  // storage
  // ****************************************************************
  // parameter bank; a rejected write leaves the word as it was
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      paramBank <= ipb_pkg::PARAM_RESET;
    end
    else if (wrTake && wrOk && inBank)
    begin
      paramBank[pos] <= merged;
    end
  end

  // lamp configuration slots
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      lampCfg <= ipb_pkg::CFG_RESET;
    end
    else if (wrTake && wrOk && isCfg)
    begin
      lampCfg[cfgSel] <= merged[3:0];
    end
  end

  // event pulse and last code for status
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      logEvent  <= '0;
      lastEvent <= 8'h00;
    end
    else if (wrTake && evHit)
    begin
      logEvent  <= '{valid: 1'b1, code: evCode};
      lastEvent <= evCode;
    end
    else
    begin
      logEvent.valid <= 1'b0;
    end
  end

  // ****************************************************************
  // calibrator lamp sequencing
  // ****************************************************************
  // dark interval: lamps off for LAMP_OFF_CYCLES, then send
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      seqState   <= ipb_pkg::SEQ_IDLE;
      darkCnt    <= 32'h0000_0000;
      pendIdx    <= 7'h00;
      savedLamps <= 6'h00;
    end
    else
    begin
      case (seqState)
        ipb_pkg::SEQ_IDLE:
        begin
          darkCnt <= 32'h0000_0000;
          if (wrTake && wrOk && lampIdx)
          begin
            seqState   <= ipb_pkg::SEQ_DARK;
            pendIdx    <= idx;
            savedLamps <= calCmd.lampOn;
          end
        end
        ipb_pkg::SEQ_DARK:
        begin
          // time counted only here, so a short parameter is safe
          if (darkCnt >= LAMP_OFF_CYCLES - 32'h1)
          begin
            seqState <= ipb_pkg::SEQ_SEND;
          end
          else
          begin
            darkCnt <= darkCnt + 32'h1;
          end
        end
        ipb_pkg::SEQ_SEND:
        begin
          seqState <= ipb_pkg::SEQ_IDLE;
        end
        default:
        begin
          seqState <= ipb_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // commands to the calibrator; level, heater, ir follow directly
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      calCmd <= '{radianceFb: 1'b1, ovpDisable: 1'b1, lampHigh: 1'b1,
                 lampOn: 6'h00, irSourceOn: 1'b0, heaterOn: 1'b0};
    end
    else
    begin
      calCmd.lampHigh   <= 1'(bankAt(ipb_pkg::LAMP_LEVEL_SELECT));
      calCmd.irSourceOn <= 1'(bankAt(ipb_pkg::IR_SOURCE_ENABLE));
      calCmd.heaterOn   <= 1'(bankAt(ipb_pkg::PHOTODIODE_HEATER_ENABLE));
      if (seqState == ipb_pkg::SEQ_IDLE && wrTake && wrOk && lampIdx)
      begin
        calCmd.lampOn <= 6'h00;
      end
      else if (seqState == ipb_pkg::SEQ_SEND)
      begin
        calCmd.radianceFb <= 1'(bankAt(ipb_pkg::SPHERE_FEEDBACK_MODE));
        calCmd.ovpDisable <= 1'(bankAt(ipb_pkg::LAMP_OVERVOLTAGE_SHUTDOWN));
        if (pendIdx == ipb_pkg::LAMP_POWER_SELECT)
        begin
          calCmd.lampOn <= lampPattern(bankAt(ipb_pkg::LAMP_POWER_SELECT));
        end
        else if ((pendIdx == ipb_pkg::LAMP_OVERVOLTAGE_SHUTDOWN) &&
                 (bankAt(ipb_pkg::LAMP_OVERVOLTAGE_SHUTDOWN) == ipb_pkg::OVP_DISABLE))
        begin
          calCmd.lampOn <= 6'h00;
        end
        else
        begin
          calCmd.lampOn <= savedLamps;
        end
      end
    end
  end

  // ****************************************************************
  // derived focal-plane and formatter values
  // ****************************************************************
  // charge subtraction borrows the calibration bias when on
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      smwChargeSubBias <= 8'h00;
      lwChargeSubBias  <= 8'h00;
      encoderOffset    <= 14'h0000;
    end
    else
    begin
      smwChargeSubBias <= 1'(bankAt(ipb_pkg::SMW_CHARGE_SUBTRACT_ENABLE)) ?
                          8'(bankAt(ipb_pkg::SMW_CAL_BIAS)) : 8'h00;
      lwChargeSubBias  <= 1'(bankAt(ipb_pkg::LW_CHARGE_SUBTRACT_ENABLE)) ?
                          8'(bankAt(ipb_pkg::LW_CAL_BIAS)) : 8'h00;
      encoderOffset    <= 14'(bankAt(ipb_pkg::ENCODER_VIEW_OFFSET));
    end
  end

endmodule : ipb_instrument_parameter_bank

//--- ipb_bank_monitor.sv
`timescale 1ns/100ps
module ipb_bank_monitor #(
  parameter int unsigned LAMP_OFF_CYCLES = 8
) (
  input wire logic                mclk,
  input wire logic                rst_n,
  input wire ipb_pkg::ipb_bank_t  paramBank,
  input wire ipb_pkg::ipb_cal_t   calCmd,
  input wire logic [7:0]          smwChargeSubBias,
  input wire logic [7:0]          lwChargeSubBias,
  input wire logic [13:0]         encoderOffset,
  input wire ipb_pkg::ipb_event_t logEvent
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  int unsigned darkCnt;  // cycles with every lamp dark
  // counts the dark stretch that must precede any lamp turn-on
  always_ff @(posedge mclk)
  begin
    if (!rst_n || (calCmd.lampOn != 6'h00))
      darkCnt <= 0;
    else
      darkCnt <= darkCnt + 1;
  end
  property p_rst; $rose(rst_n) |-> paramBank == ipb_pkg::PARAM_RESET; endproperty
  a_rst: assert property (p_rst) else $error("bank not at defaults");
  property p_cal; $rose(rst_n) |-> calCmd == 11'h700; endproperty
  a_cal: assert property (p_cal) else $error("calibrator not at defaults");
  property p_enc; encoderOffset == $past(paramBank[24][13:0]); endproperty
  a_enc: assert property (p_enc) else $error("encoder offset wrong");
  property p_charge_subtraction;
    smwChargeSubBias == ($past(paramBank[13][0]) ? $past(paramBank[6][7:0]) : 8'h00) &&
    lwChargeSubBias == ($past(paramBank[14][0]) ? $past(paramBank[10][7:0]) : 8'h00);
  endproperty
  a_charge_subtraction: assert property (p_charge_subtraction) else $error("charge subtract bias wrong");
  property p_lvl; calCmd.lampHigh == $past(paramBank[39][0]); endproperty
  a_lvl: assert property (p_lvl) else $error("lamp level wrong");
  property p_src;
    {calCmd.heaterOn, calCmd.irSourceOn} == {$past(paramBank[36][0]), $past(paramBank[41][0])};
  endproperty
  a_src: assert property (p_src) else $error("heater or source wrong");
  property p_keep; logEvent.valid |-> paramBank == $past(paramBank); endproperty
  a_keep: assert property (p_keep) else $error("rejected write stored");
  property p_dark; $rose(|calCmd.lampOn) |-> darkCnt >= LAMP_OFF_CYCLES; endproperty
  a_dark: assert property (p_dark) else $error("lamps lit too early");
  property p_ovp; $rose(calCmd.ovpDisable) |-> calCmd.lampOn == 6'h00; endproperty
  a_ovp: assert property (p_ovp) else $error("lamps lit after shutdown off");
endmodule : ipb_bank_monitor
bind ipb_instrument_parameter_bank ipb_bank_monitor #(.LAMP_OFF_CYCLES(LAMP_OFF_CYCLES)) mon (
  .mclk, .rst_n, .paramBank, .calCmd, .smwChargeSubBias, .lwChargeSubBias,
  .encoderOffset, .logEvent);

//--- ipb_cmd_source.sv
`timescale 1ns/100ps
module ipb_cmd_source (
  input  wire logic        mclk,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output logic [8:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata
);
  logic [15:0] rdata;  // value of the last read
  initial {avs_address, avs_read, avs_write, avs_writedata} = '0;
  // one parameter per transfer, held until waitrequest is seen low
  task automatic xfer(input logic [6:0] n, input logic wr, input logic [15:0] d);
    int i;
    @(posedge mclk);
    avs_address   <= {n, 2'b00};
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_writedata <= {16'h0000, d};
    for (i = 0; i < 99; i++)
    begin
      @(posedge mclk);
      if (!avs_waitrequest) break;
    end
    if (i == 99) tb_instrument_parameter_bank.give_up();
    rdata = avs_readdata[15:0];
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    // released lines must not keep their old value
    avs_address   <= ~avs_address;
    avs_writedata <= ~avs_writedata;
  endtask : xfer
endmodule : ipb_cmd_source

//--- tb_instrument_parameter_bank.sv
`timescale 1ns/100ps
module tb_instrument_parameter_bank;
  logic                mclk = 1'b0;
  logic                rst_n = 1'b0;
  logic [8:0]          avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [31:0]         avs_writedata;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  ipb_pkg::ipb_bank_t  paramBank;
  ipb_pkg::ipb_cal_t   calCmd;
  logic [7:0]          smwChargeSubBias;
  logic [7:0]          lwChargeSubBias;
  logic [13:0]         encoderOffset;
  ipb_pkg::ipb_event_t logEvent;
  logic [7:0]          lastEv = 8'h00;  // event code, held one cycle only
  int                  bad_count = 0;
  int                  check_count = 0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) lastEv <= logEvent.valid ? logEvent.code : 8'h00;
  ipb_instrument_parameter_bank #(.LAMP_OFF_CYCLES(8)) dut (.mclk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
    .avs_waitrequest, .paramBank, .calCmd, .smwChargeSubBias, .lwChargeSubBias,
    .encoderOffset, .logEvent);
  ipb_cmd_source src (.mclk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
    .avs_write, .avs_writedata);
  task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) bad_count++;
    if (g !== e) $display("wrong value %s expected %h seen %h", what, e, g);
  endtask : cmp
  task automatic wr(input logic [6:0] n, input logic [15:0] d);
    src.xfer(n, 1'b1, d);
  endtask : wr
  task automatic rc(input logic [6:0] n, input logic [15:0] e);
    src.xfer(n, 1'b0, 16'h0000);
    cmp("param", e, src.rdata);
  endtask : rc
  task automatic ev(input logic [7:0] e);
    repeat (2) @(posedge mclk);
    cmp("event", {8'h00, e}, {8'h00, lastEv});
  endtask : ev
  // lamps settle one cycle after the eight-cycle dark interval
  task automatic lit(input logic [5:0] e);
    repeat (10) @(posedge mclk);
    cmp("lamps", {10'h000, e}, {10'h000, calCmd.lampOn});
  endtask : lit
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic give_up;
    bad_count++;
    complete_run();
  endtask : give_up
  initial
  begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    for (int n = 0; n < 44; n++) rc(7'h23 + 7'(n), ipb_pkg::PARAM_RESET[n]);
    wr(7'h46, 16'h0028); rc(7'h46, 16'h0028);
    wr(7'h46, 16'h0029); ev(8'h49); rc(7'h46, 16'h0028);
    wr(7'h4f, 16'h0001); ev(8'h48);
    wr(7'h46, 16'h0000); ev(8'h49);
    wr(7'h36, 16'h0005); rc(7'h36, 16'h0000);
    wr(7'h3b, 16'he000); rc(7'h3b, 16'he000);
    cmp("encoder", 16'h2000, {2'b00, encoderOffset});
    wr(7'h30, 16'h0001); wr(7'h31, 16'h0001); rc(7'h31, 16'h0001);
    cmp("charge_subtraction", 16'h001d, {8'h00, smwChargeSubBias});
    cmp("lwcsub", 16'h001d, {8'h00, lwChargeSubBias});
    wr(7'h4b, 16'h0005); ev(8'h18);
    wr(7'h4b, 16'h0002); lit(6'h08);
    wr(7'h49, 16'h0000); lit(6'h08);
    wr(7'h48, 16'h0000); lit(6'h08);
    cmp("feedback", 16'h0000, {15'h0000, calCmd.radianceFb});
    wr(7'h49, 16'h0001); lit(6'h00);
    cmp("ovp", 16'h0001, {15'h0000, calCmd.ovpDisable});
    complete_run();
  end
endmodule : tb_instrument_parameter_bank
